/* common/decode_if.sv */
// decoded instruction fields passed from the field decoder to the executor
`timescale 1ns/1ns
interface decode_if;
  logic [15:0] instr;
  minicpu_pkg::op_t op;
  logic [3:0] r1;
  logic [3:0] r2;
  logic [3:0] dst;
  logic [1:0] mode;
  logic store;
  logic [7:0] konst;
  logic priv;

  modport dec (input instr, output op, r1, r2, dst, mode, store, konst, priv);
  modport exe (output instr, input op, r1, r2, dst, mode, store, konst, priv);
endinterface

/* common/minicpu_pkg.sv */
// shared constants, opcodes and types for the instruction slice executor
package minicpu_pkg;
  // register map, byte addresses on the bus
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_PC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [1:0] GPR_WINDOW = 2'h1;
  localparam logic [15:0] STATUS_RESET = 16'h0004;

  // status bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_HALT = 1;
  localparam int unsigned ST_SYS = 2;
  localparam int unsigned ST_INHIBIT = 3;
  localparam int unsigned ST_VIOL = 4;
  localparam int unsigned ST_ILLEGAL = 5;

  // primary opcodes
  localparam logic [3:0] OPC_LOAD = 4'h0;
  localparam logic [3:0] OPC_INC = 4'h2;
  localparam logic [3:0] OPC_AND = 4'h4;
  localparam logic [3:0] OPC_CTL = 4'h5;
  localparam logic [3:0] OPC_XOR = 4'h6;
  localparam logic [3:0] OPC_INPUT = 4'h9;

  // function sub-fields in the constant byte
  localparam logic [7:0] K_HALT = 8'h7F;
  localparam logic [7:0] K_INHIBIT = 8'hBF;
  localparam logic [7:0] K_MONITOR = 8'h04;

  // addressing modes
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_RIND = 2'h1;
  localparam logic [1:0] MODE_DIR = 2'h2;
  localparam logic [1:0] MODE_IND = 2'h3;

  localparam logic [3:0] REG_PRIV = 4'hF;
  localparam logic [3:0] REG_SP = 4'hF;
  localparam logic [3:0] REG_NONE = 4'h0;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] INC_ONE = 16'h0001;

  typedef enum logic [4:0] {
    OP_ILLEGAL, OP_XOR_SHORT, OP_XOR_REG, OP_XOR_LONG, OP_XOR_MEM,
    OP_LOAD_SHORT, OP_LOAD_LONG, OP_LOAD_REG, OP_POP,
    OP_HALT, OP_INHIBIT, OP_MONITOR, OP_INPUT,
    OP_INC_MEM, OP_INC_REG, OP_AND_MEM, OP_AND_REG
  } op_t;
endpackage

/* hw/instr_field_decoder.sv */
// splits an instruction word into operation, fields and privilege need
`timescale 1ns/1ns
module instr_field_decoder (
  // decoded fields
  decode_if.dec d
);
  logic fmt;
  logic [3:0] opc;

  // bit 0 of the word is the msb: format, opcode 1-4, r1 5-8, mode 9-10, store 11, r2 12-15
  assign fmt = d.instr[15];
  assign opc = d.instr[14:11];
  assign d.r1 = d.instr[10:7];
  assign d.mode = d.instr[6:5];
  assign d.store = d.instr[4];
  assign d.r2 = d.instr[3:0];
  assign d.konst = d.instr[7:0];

  always_comb begin
    d.op = minicpu_pkg::OP_ILLEGAL;
    d.dst = d.instr[10:7];
    if (!fmt) begin
      // short forms name a 3-bit target in bits 5-7
      d.dst = {1'b0, d.instr[10:8]};
      unique case (opc)
        minicpu_pkg::OPC_XOR: d.op = minicpu_pkg::OP_XOR_SHORT;
        minicpu_pkg::OPC_LOAD: d.op = minicpu_pkg::OP_LOAD_SHORT;
        minicpu_pkg::OPC_AND: begin
          if (d.konst == minicpu_pkg::K_HALT) d.op = minicpu_pkg::OP_HALT;
          else if (d.konst == minicpu_pkg::K_INHIBIT) d.op = minicpu_pkg::OP_INHIBIT;
        end
        minicpu_pkg::OPC_CTL: begin
          if (d.konst == minicpu_pkg::K_MONITOR) d.op = minicpu_pkg::OP_MONITOR;
        end
        minicpu_pkg::OPC_INPUT: begin
          if (!d.instr[7]) d.op = minicpu_pkg::OP_INPUT;
        end
        default: d.op = minicpu_pkg::OP_ILLEGAL;
      endcase
    end else begin
      unique case (opc)
        minicpu_pkg::OPC_XOR: begin
          if (d.mode == minicpu_pkg::MODE_RIND && d.r2 == minicpu_pkg::REG_NONE && !d.store)
            d.op = minicpu_pkg::OP_XOR_LONG;
          else if (d.mode[1]) d.op = minicpu_pkg::OP_XOR_MEM;
          else d.op = minicpu_pkg::OP_XOR_REG;
        end
        minicpu_pkg::OPC_LOAD: begin
          if (d.mode == minicpu_pkg::MODE_RIND && d.r2 == minicpu_pkg::REG_NONE)
            d.op = minicpu_pkg::OP_LOAD_LONG;
          else if (d.mode == minicpu_pkg::MODE_RIND && d.r2 == minicpu_pkg::REG_SP)
            d.op = minicpu_pkg::OP_POP;
          else if (!d.mode[1]) d.op = minicpu_pkg::OP_LOAD_REG;
        end
        minicpu_pkg::OPC_AND: begin
          if (d.mode[1]) d.op = minicpu_pkg::OP_AND_MEM;
          else d.op = minicpu_pkg::OP_AND_REG;
        end
        minicpu_pkg::OPC_INC: begin
          if (d.r1 == minicpu_pkg::REG_NONE && d.mode[1]) d.op = minicpu_pkg::OP_INC_MEM;
          else if (d.r1 == minicpu_pkg::REG_NONE && d.mode == minicpu_pkg::MODE_RIND)
            d.op = minicpu_pkg::OP_INC_REG;
        end
        default: d.op = minicpu_pkg::OP_ILLEGAL;
      endcase
    end
  end

  // register 15 as destination, halt, inhibit, input and pop need system mode; the monitor call does not
  always_comb begin
    unique case (d.op)
      minicpu_pkg::OP_HALT, minicpu_pkg::OP_INHIBIT, minicpu_pkg::OP_INPUT,
      minicpu_pkg::OP_POP: d.priv = 1'b1;
      minicpu_pkg::OP_INC_MEM, minicpu_pkg::OP_INC_REG, minicpu_pkg::OP_MONITOR,
      minicpu_pkg::OP_ILLEGAL: d.priv = 1'b0;
      default: d.priv = (d.dst == minicpu_pkg::REG_PRIV) && !(d.mode[1] && d.store);
    endcase
  end
endmodule

/* hw/minicomputer_instr_decode_xor_to_and.sv */
// executor for the xor-to-and instruction slice with an apb register port
//
// Behaviour
// - short xor: constant into low byte, one cycle
// - long constant forms: fetch word, two cycles
// - register 15 destination needs system mode
// - halt: enter halt mode, system mode only
// - inhibit: prohibit all interrupts, system only
// - monitor call: user to system mode
// - input: device word to register, privileged
// - short load: constant low, high byte cleared
// - increment memory: four or five cycles
// - stack pop: sp plus two, then load
// - and memory: store bit picks destination
`timescale 1ns/1ns
module minicomputer_instr_decode_xor_to_and (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // main memory
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // device input channel
  output logic dev_req,
  output logic [6:0] dev_addr,
  input wire logic [15:0] dev_rdata,
  input wire logic dev_ack,
  // machine state
  output logic halted,
  output logic irq_inhibit,
  output logic system_mode
);
  typedef enum logic [2:0] {S_IDLE, S_EXEC, S_EXT, S_IND, S_OPR, S_WB, S_DEV} state_t;

  state_t state;
  logic [15:0] gpr [16];
  logic [15:0] instr_q;
  logic [15:0] pc;
  logic viol;
  logic illegal;
  logic access;
  logic wr_fire;
  logic sel_instr;
  logic sel_pc;
  logic sel_status;
  logic sel_gpr;
  logic mapped;
  logic start;
  logic deny;
  logic bad_op;
  logic does_store;
  logic [15:0] index_val;
  logic [15:0] ext_addr;
  logic [15:0] result;
  logic [15:0] status_word;
  logic [31:0] next_prdata;

  decode_if d ();

  instr_field_decoder u_decode (
    .d(d)
  );

  assign d.instr = instr_q;

  // bus decode; the access completes at the edge where pready is seen high
  assign access = psel && penable && !pready;
  assign wr_fire = psel && penable && pready && pwrite;
  assign sel_instr = paddr == minicpu_pkg::ADDR_INSTR;
  assign sel_pc = paddr == minicpu_pkg::ADDR_PC;
  assign sel_status = paddr == minicpu_pkg::ADDR_STATUS;
  assign sel_gpr = paddr[7:6] == minicpu_pkg::GPR_WINDOW && paddr[1:0] == 2'h0;
  assign mapped = sel_instr || sel_pc || sel_status || sel_gpr;

  // a new instruction only starts from idle and outside halt mode
  assign start = wr_fire && sel_instr && state == S_IDLE && !halted;

  assign deny = d.priv && !system_mode;
  assign bad_op = d.op == minicpu_pkg::OP_ILLEGAL;
  assign does_store = d.op == minicpu_pkg::OP_INC_MEM || d.op == minicpu_pkg::OP_INC_REG || d.store;

  // register 0 never indexes, so a zero r2 field means no index
  assign index_val = (d.r2 == minicpu_pkg::REG_NONE) ? 16'h0000 : gpr[d.r2];
  assign ext_addr = mem_rdata + index_val;

  always_comb begin
    unique case (d.op)
      minicpu_pkg::OP_XOR_MEM, minicpu_pkg::OP_XOR_REG: result = gpr[d.r1] ^ mem_rdata;
      minicpu_pkg::OP_AND_MEM, minicpu_pkg::OP_AND_REG: result = gpr[d.r1] & mem_rdata;
      minicpu_pkg::OP_INC_MEM, minicpu_pkg::OP_INC_REG: result = mem_rdata + minicpu_pkg::INC_ONE;
      default: result = mem_rdata;
    endcase
  end

  // execution sequencer, memory port and register file
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_IDLE;
      instr_q <= 16'h0000;
      pc <= 16'h0000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      dev_req <= 1'b0;
      dev_addr <= 7'h00;
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= 16'h0000;
      end
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start) begin
            instr_q <= pwdata[15:0];
            state <= S_EXEC;
          end else if (wr_fire && sel_pc) begin
            pc <= pwdata[15:0];
          end else if (wr_fire && sel_gpr) begin
            gpr[paddr[5:2]] <= pwdata[15:0];
          end
        end
        S_EXEC: begin
          state <= S_IDLE;
          if (!deny && !bad_op) begin
            unique case (d.op)
              minicpu_pkg::OP_XOR_SHORT: gpr[d.dst][7:0] <= gpr[d.dst][7:0] ^ d.konst;
              minicpu_pkg::OP_LOAD_SHORT: gpr[d.dst] <= {8'h00, d.konst};
              minicpu_pkg::OP_XOR_REG, minicpu_pkg::OP_AND_REG, minicpu_pkg::OP_LOAD_REG: begin
                if (d.mode == minicpu_pkg::MODE_REG) begin
                  unique case (d.op)
                    minicpu_pkg::OP_XOR_REG: gpr[d.r1] <= gpr[d.r1] ^ gpr[d.r2];
                    minicpu_pkg::OP_AND_REG: gpr[d.r1] <= gpr[d.r1] & gpr[d.r2];
                    default: gpr[d.r1] <= gpr[d.r2];
                  endcase
                end else begin
                  mem_req <= 1'b1;
                  mem_addr <= gpr[d.r2];
                  state <= S_OPR;
                end
              end
              minicpu_pkg::OP_POP: begin
                gpr[minicpu_pkg::REG_SP] <= gpr[minicpu_pkg::REG_SP] + minicpu_pkg::WORD_STEP;
                mem_req <= 1'b1;
                mem_addr <= gpr[minicpu_pkg::REG_SP] + minicpu_pkg::WORD_STEP;
                state <= S_OPR;
              end
              minicpu_pkg::OP_INC_REG: begin
                mem_req <= 1'b1;
                mem_addr <= gpr[d.r2];
                state <= S_OPR;
              end
              minicpu_pkg::OP_XOR_LONG, minicpu_pkg::OP_LOAD_LONG, minicpu_pkg::OP_XOR_MEM,
              minicpu_pkg::OP_AND_MEM, minicpu_pkg::OP_INC_MEM: begin
                // the word after the instruction is a constant or an address
                mem_req <= 1'b1;
                mem_addr <= pc;
                pc <= pc + minicpu_pkg::WORD_STEP;
                state <= S_EXT;
              end
              minicpu_pkg::OP_INPUT: begin
                dev_req <= 1'b1;
                dev_addr <= instr_q[6:0];
                state <= S_DEV;
              end
              default: state <= S_IDLE;
            endcase
          end
        end
        S_EXT: begin
          if (mem_ack) begin
            unique case (d.op)
              minicpu_pkg::OP_XOR_LONG: begin
                gpr[d.r1] <= gpr[d.r1] ^ mem_rdata;
                mem_req <= 1'b0;
                state <= S_IDLE;
              end
              minicpu_pkg::OP_LOAD_LONG: begin
                gpr[d.r1] <= mem_rdata;
                mem_req <= 1'b0;
                state <= S_IDLE;
              end
              default: begin
                // index applies before the indirection
                mem_addr <= ext_addr;
                state <= (d.mode == minicpu_pkg::MODE_IND) ? S_IND : S_OPR;
              end
            endcase
          end
        end
        S_IND: begin
          if (mem_ack) begin
            mem_addr <= mem_rdata;
            state <= S_OPR;
          end
        end
        S_OPR: begin
          if (mem_ack) begin
            if (does_store && d.op != minicpu_pkg::OP_POP && d.op != minicpu_pkg::OP_LOAD_REG) begin
              mem_we <= 1'b1;
              mem_wdata <= result;
              state <= S_WB;
            end else begin
              gpr[d.r1] <= result;
              mem_req <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_WB: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_DEV: begin
          if (dev_ack) begin
            gpr[d.dst] <= dev_rdata;
            dev_req <= 1'b0;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // machine status; an event in the same cycle as its clear wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      halted <= 1'b0;
      irq_inhibit <= 1'b0;
      system_mode <= 1'b1;
      viol <= 1'b0;
      illegal <= 1'b0;
    end else begin
      if (state == S_EXEC && !deny && d.op == minicpu_pkg::OP_HALT) begin
        halted <= 1'b1;
      end else if (wr_fire && sel_status && pwdata[minicpu_pkg::ST_HALT]) begin
        halted <= 1'b0;
      end
      if (state == S_EXEC && !deny && d.op == minicpu_pkg::OP_INHIBIT) begin
        irq_inhibit <= 1'b1;
      end else if (wr_fire && sel_status) begin
        irq_inhibit <= pwdata[minicpu_pkg::ST_INHIBIT];
      end
      if (state == S_EXEC && d.op == minicpu_pkg::OP_MONITOR) begin
        system_mode <= 1'b1;
      end else if (wr_fire && sel_status) begin
        system_mode <= pwdata[minicpu_pkg::ST_SYS];
      end
      if (state == S_EXEC && deny && !bad_op) begin
        viol <= 1'b1;
      end else if (wr_fire && sel_status && pwdata[minicpu_pkg::ST_VIOL]) begin
        viol <= 1'b0;
      end
      if (state == S_EXEC && bad_op) begin
        illegal <= 1'b1;
      end else if (wr_fire && sel_status && pwdata[minicpu_pkg::ST_ILLEGAL]) begin
        illegal <= 1'b0;
      end
    end
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[minicpu_pkg::ST_BUSY] = state != S_IDLE;
    status_word[minicpu_pkg::ST_HALT] = halted;
    status_word[minicpu_pkg::ST_SYS] = system_mode;
    status_word[minicpu_pkg::ST_INHIBIT] = irq_inhibit;
    status_word[minicpu_pkg::ST_VIOL] = viol;
    status_word[minicpu_pkg::ST_ILLEGAL] = illegal;
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_instr) next_prdata = {16'h0000, instr_q};
    else if (sel_pc) next_prdata = {16'h0000, pc};
    else if (sel_status) next_prdata = {16'h0000, status_word};
    else if (sel_gpr) next_prdata = {16'h0000, gpr[paddr[5:2]]};
  end

  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      if (access && !pwrite) prdata <= next_prdata;
    end
  end
endmodule

/* sim/mem_dev_model.sv */
// memory and device channel model with selectable wait states
`timescale 1ns/1ns
module mem_dev_model #(
  parameter logic [15:0] DEV_PAT = 16'hC3A5
) (
  // clock and wait states
  input wire logic clk_sys,
  input wire logic [1:0] lat,
  // memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // device channel
  input wire logic dev_req,
  input wire logic [6:0] dev_addr,
  output logic [15:0] dev_rdata,
  output logic dev_ack
);
  logic [15:0] mem [256];
  logic [1:0] wait_cnt = 2'h0;
  logic [15:0] junk = 16'h5A5A;
  assign mem_ack = mem_req && wait_cnt == lat;
  assign dev_ack = dev_req && wait_cnt == lat;
  // data lines float outside an ack: a moving pattern, so stale data is never mistaken for valid
  assign mem_rdata = mem_ack ? mem[mem_addr[8:1]] : junk;
  assign dev_rdata = dev_ack ? DEV_PAT ^ {9'h000, dev_addr} : junk;
  always @(posedge clk_sys) begin
    junk <= ~junk;
    wait_cnt <= ((mem_req && !mem_ack) || (dev_req && !dev_ack)) ? wait_cnt + 2'h1 : 2'h0;
    if (mem_ack && mem_we) mem[mem_addr[8:1]] <= mem_wdata;
  end
endmodule

/* sim/minicomputer_instr_decode_xor_to_and_bench.sv */
// self-checking bench for the instruction slice executor
`timescale 1ns/1ns
module minicomputer_instr_decode_xor_to_and_bench;
  localparam logic [15:0] DEV_PAT = 16'hC3A5;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, mem_req, mem_we, mem_ack, dev_req, dev_ack, halted, irq_inhibit, system_mode;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, dev_rdata, lfsr_s = 16'h0003;
  logic [6:0] dev_addr;
  logic [1:0] lat = 2'h0;
  logic [33:0] apb_q[$];
  logic [31:0] mem_q[$];
  int bad_count = 0, checks_done = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  minicomputer_instr_decode_xor_to_and minicomputer_instr_decode_xor_to_and_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dev_req(dev_req),
    .dev_addr(dev_addr), .dev_rdata(dev_rdata), .dev_ack(dev_ack), .halted(halted), .irq_inhibit(irq_inhibit),
    .system_mode(system_mode));
  mem_dev_model #(.DEV_PAT(DEV_PAT)) mem_dev_model_inst (
    .clk_sys(clk_sys), .lat(lat), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dev_req(dev_req), .dev_addr(dev_addr),
    .dev_rdata(dev_rdata), .dev_ack(dev_ack));
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic void rnd(output logic [15:0] v);
    lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
    v = lfsr_s;
  endfunction
  function automatic logic [7:0] gpr(input int n);
    return 8'h40 + 8'(4 * n);
  endfunction
  // ce: {compare read data, expect error}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [1:0] ce,
                     output logic [15:0] got);
    apb_q.push_back({ce, 16'h0000, d});
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    got = prdata[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] g;
    apb(1'b1, a, d, 2'b00, g);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] g;
    apb(1'b0, a, e, 2'b10, g);
  endtask
  // polls busy so the next access never lands on a running instruction
  task automatic run(input logic [15:0] i);
    logic [15:0] g;
    wr(minicpu_pkg::ADDR_INSTR, i);
    g = 16'h0001;
    for (int n = 0; n < 20 && g[0] !== 1'b0; n++) apb(1'b0, minicpu_pkg::ADDR_STATUS, 16'h0, 2'b00, g);
  endtask
  always @(posedge clk_sys) begin
    logic [33:0] n;
    if (rst_n && psel && penable && pready === 1'b1) begin
      n = apb_q.size() > 0 ? apb_q.pop_front() : 34'h0;
      cmp("pslverr", {31'h0, n[32]}, {31'h0, pslverr});
      if (n[33]) cmp($sformatf("reg %h", paddr), n[31:0], prdata);
    end
    if (mem_req && mem_we && mem_ack) begin
      cmp("mem write", mem_q.size() > 0 ? mem_q.pop_front() : 32'hX, {mem_addr, mem_wdata});
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    logic [15:0] v, k, m, g;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(minicpu_pkg::ADDR_STATUS, minicpu_pkg::STATUS_RESET);
    for (int r = 1; r < 8; r++) begin
      rnd(v);
      rnd(k);
      wr(gpr(r), v);
      run({1'b0, minicpu_pkg::OPC_XOR, 3'(r), k[7:0]});
      rd(gpr(r), {v[15:8], v[7:0] ^ k[7:0]});
      run({1'b0, minicpu_pkg::OPC_LOAD, 3'(r), k[15:8]});
      rd(gpr(r), {8'h00, k[15:8]});
    end
    lat <= 2'h2;
    wr(minicpu_pkg::ADDR_PC, 16'h0020);
    wr(gpr(5), v);
    mem_dev_model_inst.mem[16] = k;
    mem_dev_model_inst.mem[17] = ~k;
    run({1'b1, minicpu_pkg::OPC_XOR, 4'h5, minicpu_pkg::MODE_RIND, 1'b0, minicpu_pkg::REG_NONE});
    rd(gpr(5), v ^ k);
    run({1'b1, minicpu_pkg::OPC_LOAD, 4'h6, minicpu_pkg::MODE_RIND, 1'b0, minicpu_pkg::REG_NONE});
    rd(gpr(6), ~k);
    rd(minicpu_pkg::ADDR_PC, 16'h0024);
    run({1'b1, minicpu_pkg::OPC_XOR, 4'h5, minicpu_pkg::MODE_REG, 1'b0, 4'h6});
    rd(gpr(5), ~v);
    rnd(m);
    mem_dev_model_inst.mem[18] = 16'h0080;
    mem_dev_model_inst.mem[19] = 16'h0082;
    mem_dev_model_inst.mem[20] = 16'h0084;
    mem_dev_model_inst.mem[21] = 16'h0086;
    mem_dev_model_inst.mem[64] = m;
    mem_dev_model_inst.mem[65] = ~m;
    mem_dev_model_inst.mem[66] = k;
    mem_dev_model_inst.mem[67] = 16'h0088;
    mem_dev_model_inst.mem[68] = 16'hFFFF;
    mem_q.push_back({16'h0080, m & ~v});
    run({1'b1, minicpu_pkg::OPC_AND, 4'h5, minicpu_pkg::MODE_DIR, 1'b1, minicpu_pkg::REG_NONE});
    run({1'b1, minicpu_pkg::OPC_AND, 4'h5, minicpu_pkg::MODE_DIR, 1'b0, minicpu_pkg::REG_NONE});
    rd(gpr(5), ~m & ~v);
    lat <= 2'h0;
    mem_q.push_back({16'h0084, k + 16'h0001});
    run({1'b1, minicpu_pkg::OPC_INC, 4'h0, minicpu_pkg::MODE_DIR, 1'b1, minicpu_pkg::REG_NONE});
    mem_q.push_back({16'h0088, 16'h0000});
    run({1'b1, minicpu_pkg::OPC_INC, 4'h0, minicpu_pkg::MODE_IND, 1'b1, minicpu_pkg::REG_NONE});
    wr(gpr(15), 16'h0060);
    mem_dev_model_inst.mem[49] = m;
    run({1'b1, minicpu_pkg::OPC_LOAD, 4'h8, minicpu_pkg::MODE_RIND, 1'b0, minicpu_pkg::REG_SP});
    rd(gpr(8), m);
    rd(gpr(15), 16'h0062);
    mem_q.push_back({16'h0062, (~m & ~v) ^ m});
    run({1'b1, minicpu_pkg::OPC_XOR, 4'h5, minicpu_pkg::MODE_RIND, 1'b1, minicpu_pkg::REG_SP});
    lat <= 2'h1;
    run({1'b0, minicpu_pkg::OPC_INPUT, 3'h2, 1'b0, 7'h2A});
    rd(gpr(2), DEV_PAT ^ 16'h002A);
    run({1'b0, minicpu_pkg::OPC_AND, 3'h0, minicpu_pkg::K_INHIBIT});
    rd(minicpu_pkg::ADDR_STATUS, 16'h000C);
    wr(gpr(1), 16'h1234);
    run({1'b0, minicpu_pkg::OPC_AND, 3'h0, minicpu_pkg::K_HALT});
    rd(minicpu_pkg::ADDR_STATUS, 16'h000E);
    cmp("machine pins", 32'h0000_0007, {29'h0, halted, irq_inhibit, system_mode});
    run({1'b0, minicpu_pkg::OPC_LOAD, 3'h1, 8'h55});
    rd(gpr(1), 16'h1234);
    wr(minicpu_pkg::ADDR_STATUS, 16'h0006);
    wr(minicpu_pkg::ADDR_STATUS, 16'h0000);
    run({1'b1, minicpu_pkg::OPC_LOAD, 4'hF, minicpu_pkg::MODE_RIND, 1'b0, minicpu_pkg::REG_NONE});
    rd(gpr(15), 16'h0062);
    run({1'b0, minicpu_pkg::OPC_AND, 3'h0, minicpu_pkg::K_HALT});
    rd(minicpu_pkg::ADDR_STATUS, 16'h0010);
    run({1'b0, minicpu_pkg::OPC_CTL, 3'h0, minicpu_pkg::K_MONITOR});
    rd(minicpu_pkg::ADDR_STATUS, 16'h0014);
    cmp("machine pins", 32'h0000_0001, {29'h0, halted, irq_inhibit, system_mode});
    // an opcode outside the slice only raises the illegal flag
    run(16'hFFFF);
    rd(minicpu_pkg::ADDR_STATUS, 16'h0034);
    apb(1'b0, 8'h0C, 16'h0000, 2'b11, g);
    apb(1'b1, 8'h30, 16'hFFFF, 2'b01, g);
    cmp("pending writes", 32'h0, 32'(mem_q.size()));
    finish_test();
  end
endmodule

/* sim/slice_exec_monitor.sv */
// port assertions for the instruction slice executor
`timescale 1ns/1ns
module slice_exec_monitor (
  // clock, reset and apb
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  // memory and device
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic dev_req,
  input wire logic [6:0] dev_addr,
  input wire logic dev_ack,
  // machine state
  input wire logic halted,
  input wire logic irq_inhibit,
  input wire logic system_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire sw_stat = psel && penable && pready && pwrite && paddr == minicpu_pkg::ADDR_STATUS;
  chk_apb_two_cycle: assert property (psel && !penable |=> ##1 pready)
    else $error("access phase not two cycles");
  chk_halt_sys: assert property ($rose(halted) |-> $past(system_mode))
    else $error("halt entered in user mode");
  chk_halt_quiet: assert property (halted |-> !mem_req && !dev_req)
    else $error("activity while halted");
  chk_halt_sw_clear: assert property ($fell(halted) |-> $past(sw_stat))
    else $error("halt left without status write");
  chk_inhibit_sys: assert property ($rose(irq_inhibit) |-> $past(system_mode) || $past(sw_stat))
    else $error("inhibit set in user mode");
  chk_inhibit_sw_clear: assert property ($fell(irq_inhibit) |-> $past(sw_stat))
    else $error("inhibit dropped by itself");
  chk_user_by_sw: assert property ($fell(system_mode) |-> $past(sw_stat))
    else $error("system mode lost without status write");
  chk_dev_priv: assert property ($rose(dev_req) |-> $past(system_mode))
    else $error("device input started in user mode");
  chk_dev_hold: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_addr))
    else $error("device request not held");
  chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
    && $stable(mem_wdata))
    else $error("memory request not held");
endmodule
bind minicomputer_instr_decode_xor_to_and slice_exec_monitor slice_exec_monitor_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack), .dev_req(dev_req), .dev_addr(dev_addr), .dev_ack(dev_ack), .halted(halted),
  .irq_inhibit(irq_inhibit), .system_mode(system_mode));
